// [common/rtcc_link_if.sv]
// Internal link between the clock core, its prescaler and its flag register.
// Assumes all parties run on ref_clk.
`timescale 1ns/100ps
interface rtcc_link_if;
    logic soft_rst;
    logic standby;
    logic [3:0] src_sel;
    logic qtr_tick;
    logic frc_tick;
    logic [7:0] evt;
    logic flg_wr;
    logic [7:0] flg_wdata;
    logic [7:0] flags;
    modport pre (input soft_rst, standby, src_sel, output qtr_tick, frc_tick);
    modport flg (input soft_rst, evt, flg_wr, flg_wdata, output flags);
endinterface : rtcc_link_if

// [common/rtcc_pkg.sv]
// Shared constants of the clock unit: register map, field layout, reset values, timing.
// Assumes an 8-bit internal CPU bus with 16-bit byte addresses.
package rtcc_pkg;
    localparam logic [15:0] ADDR_FLAGS = 16'hf067;
    localparam logic [15:0] ADDR_SEC = 16'hf068;
    localparam logic [15:0] ADDR_MIN = 16'hf069;
    localparam logic [15:0] ADDR_HR = 16'hf06a;
    localparam logic [15:0] ADDR_WK = 16'hf06b;
    localparam logic [15:0] ADDR_CTL = 16'hf06c;
    localparam logic [15:0] ADDR_IEN = 16'hf06d;
    localparam logic [15:0] ADDR_CSR = 16'hf06f;
    localparam int CTL_RUN = 7;
    localparam int CTL_FMT24 = 6;
    localparam int CTL_PM = 5;
    localparam int CTL_SRST = 4;
    localparam int CSR_RTC = 3;
    localparam logic [7:0] CTL_RST = 8'h00;
    localparam logic [7:0] IEN_RST = 8'h00;
    localparam logic [7:0] CSR_RST = 8'h08;
    localparam logic [7:0] FLAGS_RST = 8'h00;
    localparam logic [7:0] TIME_RST = 8'h00;
    localparam int EV_OVF = 7;
    localparam int EV_WEEK = 6;
    localparam int EV_DAY = 5;
    localparam int EV_HOUR = 4;
    localparam int EV_MIN = 3;
    localparam int EV_SEC = 2;
    localparam int EV_HALF = 1;
    localparam int EV_QTR = 0;
    localparam logic [7:0] SEC_LAST = 8'h59;
    localparam logic [7:0] MIN_LAST = 8'h59;
    localparam logic [7:0] HR12_LAST = 8'h11;
    localparam logic [7:0] HR24_LAST = 8'h23;
    localparam logic [7:0] HR_NOON = 8'h12;
    localparam logic [2:0] WK_LAST = 3'h6;
    localparam logic [7:0] FRC_LAST = 8'hff;
    localparam int SUBCLK_HZ = 32768;
    localparam int QTR_PER_SEC = 4;
    localparam int SUB_PER_QTR = SUBCLK_HZ / QTR_PER_SEC;
    localparam int DIV_W = 13;
    localparam int CLK_PERIOD_NS = 4;
    localparam int BUSY_NS = 32;
    localparam int BUSY_CYC = (BUSY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int BUSY_W = 4;

    typedef enum logic [1:0] {
        RTCC_IDLE = 2'b00,
        RTCC_BUSY = 2'b01
    } rtcc_busy_t;

    // Mask of divider bits that are all ones once per selected period.
    function automatic logic [DIV_W-1:0] div_mask(input logic [2:0] sel);
        logic [DIV_W-1:0] m;
        unique case (sel)
            3'h0: m = 13'h0007;
            3'h1: m = 13'h001f;
            3'h2: m = 13'h007f;
            3'h3: m = 13'h00ff;
            3'h4: m = 13'h01ff;
            3'h5: m = 13'h07ff;
            3'h6: m = 13'h0fff;
            3'h7: m = 13'h1fff;
        endcase
        return m;
    endfunction : div_mask
endpackage : rtcc_pkg

// [core/rtcc_flags.sv]
// Interrupt flag register: events set bits, software clears by writing 0.
// Assumes events are one-cycle pulses from the core.
`timescale 1ns/100ps
module rtcc_flags (
    // Clock and reset.
    input logic ref_clk,
    input logic sys_rst,
    // Link to the core.
    rtcc_link_if.flg lnk
);
    import rtcc_pkg::*;

    logic [7:0] flg_r, flg_nxt;

    always_comb begin
        flg_nxt = flg_r;
        if (lnk.flg_wr) begin
            flg_nxt = flg_r & lnk.flg_wdata;
        end
        flg_nxt = flg_nxt | lnk.evt;
        if (lnk.soft_rst) begin
            flg_nxt = FLAGS_RST;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            flg_r <= FLAGS_RST;
        end else begin
            flg_r <= flg_nxt;
        end
    end

    assign lnk.flags = flg_r;

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (sys_rst);

    a_flag_set: assert property (
        (lnk.evt != 8'h00 && !lnk.soft_rst)
            |=> (lnk.flags & $past(lnk.evt)) == $past(lnk.evt)
    ) else $error("Event did not set its flag.");

    a_flag_clear: assert property (
        (lnk.flg_wr && !lnk.soft_rst)
            |=> (lnk.flags & ~$past(lnk.flg_wdata) & ~$past(lnk.evt)) == 8'h00
    ) else $error("Flag written 0 was not cleared.");
endmodule : rtcc_flags

// [core/rtcc_prescaler.sv]
// Counting clock source: system clock divider taps and subclock quarter-second ticks.
// Assumes sub_clk_in is already synchronous to ref_clk.
`timescale 1ns/100ps
module rtcc_prescaler #(
    parameter int SUB_PER_QTR = rtcc_pkg::SUB_PER_QTR
) (
    // Clock and reset.
    input logic ref_clk,
    input logic sys_rst,
    // Subclock level.
    input logic sub_clk_in,
    // Link to the core.
    rtcc_link_if.pre lnk
);
    import rtcc_pkg::*;

    logic [DIV_W-1:0] div_r, div_nxt;
    logic [DIV_W-1:0] sub_cnt_r, sub_cnt_nxt;
    logic [DIV_W-1:0] mask;
    logic sub_q_r, sub_q_nxt;
    logic qtr_r, qtr_nxt;
    logic frc_r, frc_nxt;
    logic sub_edge;
    logic [3:0] d8_run_r, d8_run_nxt;

    always_comb begin
        mask = div_mask(lnk.src_sel[2:0]);
        sub_edge = sub_clk_in && !sub_q_r;
        sub_q_nxt = sub_clk_in;
        div_nxt = div_r + DIV_W'(1);
        sub_cnt_nxt = sub_cnt_r;
        qtr_nxt = 1'b0;
        if (sub_edge) begin
            if (sub_cnt_r == DIV_W'(SUB_PER_QTR - 1)) begin
                sub_cnt_nxt = '0;
                qtr_nxt = lnk.src_sel[CSR_RTC];
            end else begin
                sub_cnt_nxt = sub_cnt_r + DIV_W'(1);
            end
        end
        frc_nxt = !lnk.src_sel[CSR_RTC] && ((div_r & mask) == mask);
        if (lnk.soft_rst || lnk.standby) begin
            div_nxt = '0;
            sub_cnt_nxt = '0;
            qtr_nxt = 1'b0;
            frc_nxt = 1'b0;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            div_r <= '0;
            sub_cnt_r <= '0;
            sub_q_r <= 1'b0;
            qtr_r <= 1'b0;
            frc_r <= 1'b0;
        end else begin
            div_r <= div_nxt;
            sub_cnt_r <= sub_cnt_nxt;
            sub_q_r <= sub_q_nxt;
            qtr_r <= qtr_nxt;
            frc_r <= frc_nxt;
        end
    end

    // Cycles in a row with the divide-by-8 tap selected and the divider running.
    always_comb begin
        d8_run_nxt = d8_run_r;
        if ((lnk.src_sel != 4'h0) || lnk.soft_rst || lnk.standby) begin
            d8_run_nxt = 4'h0;
        end else if (d8_run_r != 4'hf) begin
            d8_run_nxt = d8_run_r + 4'h1;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            d8_run_r <= 4'h0;
        end else begin
            d8_run_r <= d8_run_nxt;
        end
    end

    assign lnk.qtr_tick = qtr_r;
    assign lnk.frc_tick = frc_r;

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (sys_rst);

    a_qtr_source: assert property (
        lnk.qtr_tick |-> $past(lnk.src_sel[CSR_RTC])
    ) else $error("Quarter tick issued outside clock mode.");

    a_div8_period: assert property (
        (d8_run_r >= 4'h9) |-> lnk.frc_tick == $past(lnk.frc_tick, 8)
    ) else $error("Divide-by-8 tick spacing is wrong.");

    a_halt_quiet: assert property (
        lnk.soft_rst |=> !lnk.qtr_tick && !lnk.frc_tick
    ) else $error("Tick issued during soft reset.");
endmodule : rtcc_prescaler

// [core/rtcc_top.sv]
// Real-time clock core: time counters, control registers and CPU bus access.
// Assumes an 8-bit internal bus and a subclock synchronous to ref_clk.
//
// What this block does
// - Run bit stops or starts counting.
// - Twelve-hour format keeps hours 0 to 11.
// - Twenty-four-hour format keeps hours 0 to 23.
// - Afternoon bit shows morning or afternoon.
// - Soft reset clears all but source select and the soft reset bit.
// - Soft reset also resets internal control logic.
// - Four readable writable 8-bit time registers.
// - Time registers sit on CPU bus.
// - Counting clock from divider taps or subclock.
// - Source select register chooses counting clock.
// - Eight interrupt enables in control two.
// - Each interrupt source sets a status flag.
// - Module standby switches the unit off.
// - Periodic events fire once per period.
// - Flags set by events, cleared writing 0.
// - Busy bit shown while seconds update.
`timescale 1ns/100ps
module rtcc_top #(
    parameter int SUB_PER_QTR = rtcc_pkg::SUB_PER_QTR
) (
    // Clock and reset.
    input logic ref_clk,
    input logic sys_rst,
    // Internal CPU bus.
    input logic [15:0] bus_addr,
    input logic bus_wr,
    input logic bus_rd,
    input logic [7:0] bus_wdata,
    output logic [7:0] bus_rdata,
    // Subclock and power control.
    input logic sub_clk_in,
    input logic module_standby,
    // Interrupt request.
    output logic irq_req
);
    import rtcc_pkg::*;

    rtcc_link_if lnk ();

    logic [7:0] ctl_r, ctl_nxt;
    logic [7:0] ien_r, ien_nxt;
    logic [7:0] csr_r, csr_nxt;
    logic [7:0] sec_r, sec_nxt;
    logic [7:0] min_r, min_nxt;
    logic [7:0] hr_r, hr_nxt;
    logic [2:0] wk_r, wk_nxt;
    logic [1:0] qph_r, qph_nxt;
    rtcc_busy_t st_r, st_nxt;
    logic [BUSY_W-1:0] bcnt_r, bcnt_nxt;
    logic [7:0] rdata_nxt;
    logic irq_nxt;
    logic [7:0] evt;
    logic [8:0] st_s, st_m, st_h;
    logic srst, run, rtc_mode, acc, busy, sec_upd, hr_inc;

    // BCD step with wrap: bit 8 is the carry out at the last value.
    function automatic logic [8:0] bcd_step(input logic [7:0] v, input logic [7:0] last);
        logic [7:0] inc;
        inc = v + 8'h01;
        if (v[3:0] == 4'h9) begin
            inc = {v[7:4] + 4'h1, 4'h0};
        end
        return (v == last) ? 9'h100 : {1'b0, inc};
    endfunction : bcd_step

    assign srst = ctl_r[CTL_SRST];
    assign acc = !module_standby;
    assign run = ctl_r[CTL_RUN] && acc;
    assign rtc_mode = csr_r[CSR_RTC];
    assign busy = (st_r == RTCC_BUSY);

    assign lnk.soft_rst = srst;
    assign lnk.standby = module_standby;
    assign lnk.src_sel = csr_r[3:0];
    assign lnk.evt = evt;
    assign lnk.flg_wr = bus_wr && acc && (bus_addr == ADDR_FLAGS);
    assign lnk.flg_wdata = bus_wdata;

    rtcc_prescaler #(
        .SUB_PER_QTR(SUB_PER_QTR)
    ) u_pre (
        .ref_clk(ref_clk),
        .sys_rst(sys_rst),
        .sub_clk_in(sub_clk_in),
        .lnk(lnk.pre)
    );

    rtcc_flags u_flg (
        .ref_clk(ref_clk),
        .sys_rst(sys_rst),
        .lnk(lnk.flg)
    );

    // Time counting, register writes and soft reset.
    always_comb begin
        sec_nxt = sec_r;
        min_nxt = min_r;
        hr_nxt = hr_r;
        wk_nxt = wk_r;
        qph_nxt = qph_r;
        ctl_nxt = ctl_r;
        ien_nxt = ien_r;
        csr_nxt = csr_r;
        evt = 8'h00;
        sec_upd = 1'b0;
        hr_inc = 1'b0;
        st_s = bcd_step(sec_r, SEC_LAST);
        st_m = bcd_step(min_r, MIN_LAST);
        st_h = bcd_step(hr_r, ctl_r[CTL_FMT24] ? HR24_LAST : HR12_LAST);
        if (run && rtc_mode && lnk.qtr_tick) begin
            qph_nxt = qph_r + 2'h1;
            evt[EV_QTR] = 1'b1;
            evt[EV_HALF] = qph_r[0];
            if (qph_r == 2'h3) begin
                sec_upd = 1'b1;
                evt[EV_SEC] = 1'b1;
                sec_nxt = st_s[7:0];
                if (st_s[8]) begin
                    evt[EV_MIN] = 1'b1;
                    min_nxt = st_m[7:0];
                    if (st_m[8]) begin
                        evt[EV_HOUR] = 1'b1;
                        hr_nxt = st_h[7:0];
                        hr_inc = 1'b1;
                        if (ctl_r[CTL_FMT24]) begin
                            evt[EV_DAY] = st_h[8];
                        end else begin
                            evt[EV_DAY] = st_h[8] && ctl_r[CTL_PM];
                            ctl_nxt[CTL_PM] = ctl_r[CTL_PM] ^ st_h[8];
                        end
                        if (evt[EV_DAY]) begin
                            wk_nxt = (wk_r == WK_LAST) ? 3'h0 : wk_r + 3'h1;
                            evt[EV_WEEK] = (wk_r == WK_LAST);
                        end
                    end
                end
            end
        end
        if (run && !rtc_mode && lnk.frc_tick) begin
            sec_nxt = sec_r + 8'h01;
            evt[EV_OVF] = (sec_r == FRC_LAST);
        end
        if (bus_wr && acc) begin
            case (bus_addr)
                ADDR_SEC: sec_nxt = rtc_mode ? {1'b0, bus_wdata[6:0]} : bus_wdata;
                ADDR_MIN: min_nxt = {1'b0, bus_wdata[6:0]};
                ADDR_HR: hr_nxt = {2'b00, bus_wdata[5:0]};
                ADDR_WK: wk_nxt = bus_wdata[2:0];
                ADDR_CTL: ctl_nxt = {bus_wdata[7:4], 4'h0};
                ADDR_IEN: ien_nxt = bus_wdata;
                ADDR_CSR: csr_nxt = {1'b0, bus_wdata[6:0]};
                default: ;
            endcase
        end
        if (ctl_nxt[CTL_FMT24]) begin
            ctl_nxt[CTL_PM] = (hr_nxt >= HR_NOON);
        end
        if (srst) begin
            sec_nxt = TIME_RST;
            min_nxt = TIME_RST;
            hr_nxt = TIME_RST;
            wk_nxt = TIME_RST[2:0];
            qph_nxt = 2'h0;
            ien_nxt = IEN_RST;
            ctl_nxt = {CTL_RST[7:5], ctl_nxt[CTL_SRST], CTL_RST[3:0]};
            evt = 8'h00;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            ctl_r <= CTL_RST;
            ien_r <= IEN_RST;
            csr_r <= CSR_RST;
            sec_r <= TIME_RST;
            min_r <= TIME_RST;
            hr_r <= TIME_RST;
            wk_r <= TIME_RST[2:0];
            qph_r <= 2'h0;
        end else begin
            ctl_r <= ctl_nxt;
            ien_r <= ien_nxt;
            csr_r <= csr_nxt;
            sec_r <= sec_nxt;
            min_r <= min_nxt;
            hr_r <= hr_nxt;
            wk_r <= wk_nxt;
            qph_r <= qph_nxt;
        end
    end

    // Busy window opened by each seconds update.
    always_comb begin
        st_nxt = st_r;
        bcnt_nxt = bcnt_r;
        unique case (st_r)
            RTCC_IDLE: begin
                if (sec_upd) begin
                    st_nxt = RTCC_BUSY;
                    bcnt_nxt = BUSY_W'(BUSY_CYC - 1);
                end
            end
            RTCC_BUSY: begin
                if (bcnt_r == '0) begin
                    st_nxt = RTCC_IDLE;
                end else begin
                    bcnt_nxt = bcnt_r - BUSY_W'(1);
                end
            end
            default: begin
                st_nxt = RTCC_IDLE;
            end
        endcase
        if (srst) begin
            st_nxt = RTCC_IDLE;
            bcnt_nxt = '0;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            st_r <= RTCC_IDLE;
            bcnt_r <= '0;
        end else begin
            st_r <= st_nxt;
            bcnt_r <= bcnt_nxt;
        end
    end

    // Read data and interrupt request.
    always_comb begin
        rdata_nxt = bus_rdata;
        if (bus_rd) begin
            rdata_nxt = 8'h00;
            if (acc) begin
                case (bus_addr)
                    ADDR_FLAGS: rdata_nxt = lnk.flags;
                    ADDR_SEC: rdata_nxt = rtc_mode ? {busy, sec_r[6:0]} : sec_r;
                    ADDR_MIN: rdata_nxt = {busy, min_r[6:0]};
                    ADDR_HR: rdata_nxt = {busy, 1'b0, hr_r[5:0]};
                    ADDR_WK: rdata_nxt = {5'h00, wk_r};
                    ADDR_CTL: rdata_nxt = {ctl_r[7:4], 4'h0};
                    ADDR_IEN: rdata_nxt = ien_r;
                    ADDR_CSR: rdata_nxt = {1'b0, csr_r[6:0]};
                    default: ;
                endcase
            end
        end
        irq_nxt = |(lnk.flags & ien_r);
    end

    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            bus_rdata <= 8'h00;
            irq_req <= 1'b0;
        end else begin
            bus_rdata <= rdata_nxt;
            irq_req <= irq_nxt;
        end
    end

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (sys_rst);

    sequence s_sec_update;
        sec_upd && !srst;
    endsequence

    sequence s_busy_window;
        busy[*8] ##1 !busy;
    endsequence

    a_busy_window: assert property (
        disable iff (sys_rst || srst)
        s_sec_update |=> s_busy_window
    ) else $error("Busy flag did not cover the update window.");

    a_stop_holds: assert property (
        (!ctl_r[CTL_RUN] && !bus_wr && !srst)
            |=> sec_r == $past(sec_r) && min_r == $past(min_r) && hr_r == $past(hr_r)
    ) else $error("Time changed while stopped.");

    a_hour_12: assert property (
        (hr_inc && !ctl_r[CTL_FMT24] && hr_r == HR12_LAST && !bus_wr && !srst)
            |=> hr_r == 8'h00 && ctl_r[CTL_PM] != $past(ctl_r[CTL_PM])
    ) else $error("Twelve-hour wrap wrong.");

    a_hour_24: assert property (
        (hr_inc && ctl_r[CTL_FMT24] && hr_r == HR24_LAST && !bus_wr && !srst)
            |=> hr_r == 8'h00 && !ctl_r[CTL_PM]
    ) else $error("Twenty-four-hour wrap wrong.");

    a_soft_reset: assert property (
        (srst && !bus_wr)
            |=> sec_r == 8'h00 && min_r == 8'h00 && hr_r == 8'h00 && wk_r == 3'h0
                && ien_r == 8'h00 && !ctl_r[CTL_RUN] && csr_r == $past(csr_r)
    ) else $error("Soft reset left state behind.");

    a_sec_carry: assert property (
        (sec_upd && sec_r == SEC_LAST && !bus_wr && !srst)
            |=> sec_r == 8'h00 && min_r != $past(min_r)
    ) else $error("Seconds did not carry into minutes.");

    a_frc_wrap: assert property (
        (run && !rtc_mode && lnk.frc_tick && sec_r == FRC_LAST && !bus_wr && !srst)
            |=> sec_r == 8'h00 && lnk.flags[EV_OVF]
    ) else $error("Counter overflow not flagged.");

    a_irq_gate: assert property (
        ((lnk.flags & ien_r) == 8'h00) |=> !irq_req
    ) else $error("Request raised without enabled flag.");

    a_ctl_reserved: assert property (
        (bus_rd && acc && bus_addr == ADDR_CTL) |=> bus_rdata[3:0] == 4'h0
    ) else $error("Reserved control bits read nonzero.");
endmodule : rtcc_top

// [tb/rtcc_tb.sv]
// Self-checking bench of the clock unit: bus access, counting, soft reset, free-run, standby.
// Assumes rtcc_pkg and the design files are compiled first.
`timescale 1ns/100ps
module tb;
    import rtcc_pkg::*;
    logic ref_clk = 1'b0;
    logic sys_rst = 1'b1;
    logic [15:0] bus_addr = 16'h0000;
    logic bus_wr = 1'b0;
    logic bus_rd = 1'b0;
    logic [7:0] bus_wdata = 8'h00;
    logic [7:0] bus_rdata;
    logic sub_clk_in = 1'b0;
    logic module_standby = 1'b0;
    logic irq_req;
    int err_count = 0;
    int n_checks = 0;
    int k;
    int cnt;
    int ex;
    logic [7:0] rd_v;
    logic [7:0] v;
    logic [15:0] map_a [8] = '{ADDR_FLAGS, ADDR_SEC, ADDR_MIN, ADDR_HR, ADDR_WK, ADDR_CTL,
        ADDR_IEN, ADDR_CSR};
    logic [7:0] map_r [8] = '{FLAGS_RST, TIME_RST, TIME_RST, TIME_RST, TIME_RST, CTL_RST,
        IEN_RST, CSR_RST};
    int div_sh [8] = '{3, 5, 7, 8, 9, 11, 12, 13};

    always #2 ref_clk = ~ref_clk;
    // The subclock crystal runs free, one period every ten system cycles.
    always #20 sub_clk_in = ~sub_clk_in;

    rtcc_top #(.SUB_PER_QTR(4)) dut (
        .ref_clk(ref_clk),
        .sys_rst(sys_rst),
        .bus_addr(bus_addr),
        .bus_wr(bus_wr),
        .bus_rd(bus_rd),
        .bus_wdata(bus_wdata),
        .bus_rdata(bus_rdata),
        .sub_clk_in(sub_clk_in),
        .module_standby(module_standby),
        .irq_req(irq_req)
    );

    // Two-digit packed decimal of a count.
    function automatic logic [7:0] bcd(input int n);
        return 8'((n / 10) * 16 + (n % 10));
    endfunction : bcd

    task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
        n_checks++;
        if (got !== exp) begin
            err_count++;
            $display("BAD %0t %s got %h expected %h", $time, what, got, exp);
        end
    endtask : chk

    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        @(negedge ref_clk);
        bus_addr = a;
        bus_wdata = d;
        bus_wr = 1'b1;
        @(negedge ref_clk);
        bus_wr = 1'b0;
    endtask : wr

    task automatic rd(input logic [15:0] a, output logic [7:0] d);
        @(negedge ref_clk);
        bus_addr = a;
        bus_rd = 1'b1;
        @(negedge ref_clk);
        bus_rd = 1'b0;
        @(negedge ref_clk);
        d = bus_rdata;
    endtask : rd

    task automatic rchk(input logic [15:0] a, input logic [7:0] exp, input string what);
        logic [7:0] d;
        rd(a, d);
        chk(d, exp, what);
    endtask : rchk

    // Runs the clock from 59:59 across one second and checks every carry.
    task automatic clk_run(input logic [7:0] ctl, input logic [7:0] hr, input logic [7:0] wk,
            input logic [7:0] ctl_ex, input logic [7:0] wk_ex, input logic [7:0] fl_ex);
        logic [7:0] d;
        int n;
        wr(ADDR_CSR, 8'h08);
        wr(ADDR_CTL, ctl);
        wr(ADDR_SEC, SEC_LAST);
        wr(ADDR_MIN, MIN_LAST);
        wr(ADDR_HR, hr);
        wr(ADDR_WK, wk);
        wr(ADDR_FLAGS, 8'h00);
        wr(ADDR_IEN, 8'hff);
        wr(ADDR_CTL, ctl | 8'h80);
        n = 0;
        do begin
            rd(ADDR_SEC, d);
            n++;
        end while (d[6:0] !== 7'h00 && n < 400);
        chk(d & 8'h7f, 8'h00, "seconds wrap");
        chk({7'h00, d[7]}, 8'h01, "busy after update");
        rchk(ADDR_CTL, ctl_ex, "control after wrap");
        wr(ADDR_CTL, ctl_ex & 8'h7f);
        repeat (12) @(negedge ref_clk);
        rchk(ADDR_SEC, 8'h00, "busy cleared");
        rchk(ADDR_MIN, 8'h00, "minute carry");
        rchk(ADDR_HR, 8'h00, "hour carry");
        rchk(ADDR_WK, wk_ex, "weekday carry");
        rchk(ADDR_FLAGS, fl_ex, "event flags");
        chk({7'h00, irq_req}, 8'h01, "request raised");
        wr(ADDR_FLAGS, 8'h00);
        rchk(ADDR_FLAGS, 8'h00, "flags cleared");
        chk({7'h00, irq_req}, 8'h00, "request dropped");
    endtask : clk_run

    task automatic stop_test();
        $display("checks %0d mismatches %0d", n_checks, err_count);
        if (err_count == 0 && n_checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : stop_test

    initial begin
        #200000;
        err_count++;
        $display("BAD %0t watchdog expired", $time);
        stop_test();
    end

    initial begin
        k = $urandom(29764);
        repeat (6) @(posedge ref_clk);
        @(negedge ref_clk);
        sys_rst = 1'b0;
        for (k = 0; k < 8; k++) begin
            rchk(map_a[k], map_r[k], "reset value");
        end
        wr(16'hf06e, 8'hff);
        rchk(16'hf06e, 8'h00, "unmapped read");
        for (k = 0; k < 8; k++) begin
            v = 8'($urandom);
            wr(ADDR_IEN, v);
            rchk(ADDR_IEN, v, "enables readback");
            cnt = $urandom_range(59);
            wr(ADDR_MIN, bcd(cnt));
            rchk(ADDR_MIN, bcd(cnt), "minutes readback");
            wr(ADDR_WK, 8'(k % 7));
            rchk(ADDR_WK, 8'(k % 7), "weekday readback");
            wr(ADDR_CTL, v & 8'h6f);
            rchk(ADDR_CTL, v[6] ? 8'h40 : (v & 8'h60), "reserved bits");
        end
        wr(ADDR_CTL, 8'h40);
        wr(ADDR_SEC, 8'h10);
        repeat (200) @(negedge ref_clk);
        rchk(ADDR_SEC, 8'h10, "halted count");
        clk_run(8'h40, HR24_LAST, 8'h06, 8'hc0, 8'h00, 8'h7f);
        clk_run(8'h00, HR12_LAST, 8'h06, 8'ha0, 8'h06, 8'h1f);
        @(negedge ref_clk);
        module_standby = 1'b1;
        wr(ADDR_IEN, 8'h55);
        rchk(ADDR_IEN, 8'h00, "standby read");
        module_standby = 1'b0;
        rchk(ADDR_IEN, 8'hff, "standby write dropped");
        wr(ADDR_CSR, 8'h05);
        wr(ADDR_SEC, 8'h21);
        wr(ADDR_CTL, 8'h10);
        for (k = 0; k < 5; k++) begin
            rchk(map_a[k], 8'h00, "soft reset clear");
        end
        rchk(ADDR_IEN, 8'h00, "soft reset enables");
        rchk(ADDR_CTL, 8'h10, "soft reset bit kept");
        rchk(ADDR_CSR, 8'h05, "source kept");
        wr(ADDR_CTL, 8'h00);
        rchk(ADDR_CTL, 8'h00, "soft reset left");
        for (k = 0; k < 8; k++) begin
            wr(ADDR_CSR, 8'(k));
            wr(ADDR_SEC, 8'h00);
            wr(ADDR_CTL, 8'h80);
            repeat (1024) @(negedge ref_clk);
            wr(ADDR_CTL, 8'h00);
            rd(ADDR_SEC, rd_v);
            ex = 1026 >> div_sh[k];
            n_checks++;
            if ($isunknown(rd_v) || int'(rd_v) > ex + 1 || int'(rd_v) + 1 < ex) begin
                err_count++;
                $display("BAD %0t free-run count %h sel %0d", $time, rd_v, k);
            end
        end
        wr(ADDR_CSR, 8'h00);
        wr(ADDR_FLAGS, 8'h00);
        wr(ADDR_SEC, 8'hfe);
        wr(ADDR_CTL, 8'h80);
        repeat (40) @(negedge ref_clk);
        wr(ADDR_CTL, 8'h00);
        rd(ADDR_FLAGS, rd_v);
        chk({7'h00, rd_v[7]}, 8'h01, "overflow flag");
        chk({7'h00, irq_req}, 8'h00, "masked request");
        wr(ADDR_IEN, 8'h80);
        repeat (3) @(negedge ref_clk);
        chk({7'h00, irq_req}, 8'h01, "overflow request");
        stop_test();
    end
endmodule : tb
